// ---- dual_conv_ctrl.sv ----
// Digital control and output logic of a dual 10-bit sampling converter with an AXI4-Lite status port.
//
// Contract
// - Sample both channels on falling clock edge.
// - Bus select high: both buses carry results.
// - Bus select low: interleave, second bus low.
// - Correction start rising edge: 34-cycle sequence.
// - Average 32 conversions per converter as offset.
// - Subtract offset from later conversions.
// - Format low offset binary, high two's complement.
// - Format change may corrupt one or two words.
// - Both low normal; standby alone enters standby.
// - Resume within 800 ns after standby.
// - Power-down; resume under 1 ms after release; code: first pair 1 ms plus one cycle after the release edge.
// - Power-down dominates when both are high.
// - Bit zero least, bit nine most significant.
// - Parallel words update after rising clock edge.
// - Muxed: indicator high first, low second.
// - Indicator rises to first, falls to second.
// - Parallel: indicator rises when data changes.
`timescale 1ns/1ps

module dual_conv_ctrl #(
	parameter int POWER_DOWN_WAKE = dual_conv_pkg::POWER_DOWN_WAKE_CYCLES
)
(
	// Clock, reset and clock enable.
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Static control pins and raw conversion codes from the two cores.
	input wire dual_conv_pkg::control_pins_t control_pins,
	input wire dual_conv_pkg::sample_pair_t raw_codes,
	// Result buses and channel indicator.
	output logic [9:0] first_channel_result_bus,
	output logic [9:0] second_channel_result_bus,
	output logic channel_indicator,
	// AXI4-Lite write channels.
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels.
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ****************************************************************
	// Helpers
	// ****************************************************************

	// Removes the offset, clamps to the code range and applies the output format.
	function automatic logic [9:0] correct_code(input logic [9:0] raw, input logic [10:0] off, input logic fmt);
		logic [11:0] diff;
		logic [9:0] clamped;
		diff = {2'b00, raw} - {off[10], off};
		if (diff[11])
			clamped = 10'h000;
		else if (diff[10])
			clamped = dual_conv_pkg::CODE_MAX;
		else
			clamped = diff[9:0];
		// Two's complement differs from offset binary only in the sign bit.
		correct_code = fmt ? {~clamped[9], clamped[8:0]} : clamped;
	endfunction

	// ****************************************************************
	// Sampling
	// ****************************************************************

	// Both cores are captured together on the falling edge, half a cycle before processing.
	dual_conv_pkg::sample_pair_t sampled;
	always_ff @(negedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sampled <= '0;
		else if (clk_en)
			sampled <= raw_codes;
	end

	// ****************************************************************
	// Power modes and offset correction
	// ****************************************************************
	dual_conv_pkg::power_state_t pwr_state, next_pwr_state;
	logic [16:0] wake_count, next_wake_count;
	logic correcting, next_correcting;
	logic [5:0] corr_count, next_corr_count;
	logic [14:0] acc_first, next_acc_first;
	logic [14:0] acc_second, next_acc_second;
	logic [10:0] off_first, next_off_first;
	logic [10:0] off_second, next_off_second;
	logic off_valid, next_off_valid;
	logic start_prev, next_start_prev;
	logic soft_start;

	// Mode selection, wake timing and the averaging sequence.
	always_comb
	begin
		next_pwr_state = pwr_state;
		next_wake_count = wake_count;
		next_correcting = correcting;
		next_corr_count = corr_count;
		next_acc_first = acc_first;
		next_acc_second = acc_second;
		next_off_first = off_first;
		next_off_second = off_second;
		next_off_valid = off_valid;
		next_start_prev = control_pins.offset_correct_start;
		if (control_pins.power_down_request)
		begin
			next_pwr_state = dual_conv_pkg::PWR_DOWN;
			next_wake_count = POWER_DOWN_WAKE[16:0] - 17'h00001;
		end
		else if (control_pins.standby_request)
		begin
			// Standby from power-down keeps the power-down recovery count for its first cycle only; later standby cycles load the standby count.
			// The release edge and the final wake edge are part of the budget, so two cycles come off the count.
			if (pwr_state != dual_conv_pkg::PWR_DOWN)
				next_wake_count = 17'(dual_conv_pkg::STANDBY_WAKE_CYCLES - 2);
			next_pwr_state = dual_conv_pkg::PWR_STANDBY;
		end
		else
		begin
			case (pwr_state)
				dual_conv_pkg::PWR_NORMAL:
					next_pwr_state = dual_conv_pkg::PWR_NORMAL;
				dual_conv_pkg::PWR_STANDBY, dual_conv_pkg::PWR_DOWN:
					next_pwr_state = dual_conv_pkg::PWR_WAKE;
				dual_conv_pkg::PWR_WAKE:
				begin
					if (wake_count == 17'h00000)
						next_pwr_state = dual_conv_pkg::PWR_NORMAL;
					else
						next_wake_count = wake_count - 17'h00001;
				end
				default:
					next_pwr_state = dual_conv_pkg::PWR_NORMAL;
			endcase
		end
		// A sequence is only run while converting; leaving normal mode abandons it.
		if (next_pwr_state != dual_conv_pkg::PWR_NORMAL)
			next_correcting = 1'b0;
		else if (correcting)
		begin
			if ((corr_count >= dual_conv_pkg::CORR_FIRST_ACC) && (corr_count <= dual_conv_pkg::CORR_LAST_ACC))
			begin
				next_acc_first = acc_first + {5'h00, sampled.first_channel};
				next_acc_second = acc_second + {5'h00, sampled.second_channel};
			end
			if (corr_count == dual_conv_pkg::CORR_CYCLES - 6'h01)
			begin
				next_correcting = 1'b0;
				next_off_first = {1'b0, acc_first[14:5]} - dual_conv_pkg::MID_SCALE;
				next_off_second = {1'b0, acc_second[14:5]} - dual_conv_pkg::MID_SCALE;
				next_off_valid = 1'b1;
			end
			next_corr_count = corr_count + 6'h01;
		end
		else if ((control_pins.offset_correct_start && !start_prev) || soft_start)
		begin
			next_correcting = 1'b1;
			next_corr_count = 6'h00;
			next_acc_first = '0;
			next_acc_second = '0;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pwr_state <= dual_conv_pkg::PWR_NORMAL;
			wake_count <= '0;
			correcting <= 1'b0;
			corr_count <= '0;
			acc_first <= '0;
			acc_second <= '0;
			off_first <= '0;
			off_second <= '0;
			off_valid <= 1'b0;
			start_prev <= 1'b0;
		end
		else if (clk_en)
		begin
			pwr_state <= next_pwr_state;
			wake_count <= next_wake_count;
			correcting <= next_correcting;
			corr_count <= next_corr_count;
			acc_first <= next_acc_first;
			acc_second <= next_acc_second;
			off_first <= next_off_first;
			off_second <= next_off_second;
			off_valid <= next_off_valid;
			start_prev <= next_start_prev;
		end
	end

	// ****************************************************************
	// Output formatting
	// ****************************************************************
	logic phase, next_phase;
	logic [9:0] held_second, next_held_second;
	logic [9:0] next_first_bus, next_second_bus;
	logic next_indicator;

	// A pair is issued every second cycle so the indicator can rise on each new pair.
	always_comb
	begin
		next_phase = 1'b0;
		next_held_second = held_second;
		next_first_bus = first_channel_result_bus;
		next_second_bus = second_channel_result_bus;
		next_indicator = 1'b0;
		if (pwr_state != dual_conv_pkg::PWR_NORMAL)
		begin
			next_first_bus = 10'h000;
			next_second_bus = 10'h000;
		end
		else if (!phase)
		begin
			// Format is sampled every pair; a change mid-stream costs at most the pair in flight.
			next_phase = 1'b1;
			next_first_bus = correct_code(sampled.first_channel, off_first,
				control_pins.output_format_select);
			next_held_second = correct_code(sampled.second_channel, off_second,
				control_pins.output_format_select);
			next_second_bus = control_pins.bus_select ? next_held_second : 10'h000;
			next_indicator = 1'b1;
		end
		else if (!control_pins.bus_select)
		begin
			next_first_bus = held_second;
			next_second_bus = 10'h000;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phase <= 1'b0;
			held_second <= '0;
			first_channel_result_bus <= '0;
			second_channel_result_bus <= '0;
			channel_indicator <= 1'b0;
		end
		else if (clk_en)
		begin
			phase <= next_phase;
			held_second <= next_held_second;
			first_channel_result_bus <= next_first_bus;
			second_channel_result_bus <= next_second_bus;
			channel_indicator <= next_indicator;
		end
	end

	// ****************************************************************
	// AXI4-Lite slave
	// ****************************************************************
	logic [3:0] aw_addr, next_aw_addr;
	logic aw_full, next_aw_full;
	logic [31:0] w_data, next_w_data;
	logic w_strb0, next_w_strb0;
	logic w_full, next_w_full;
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid, next_soft_start;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;

	// Address and data are taken in either order; the write lands once both are held.
	always_comb
	begin
		next_aw_addr = aw_addr;
		next_aw_full = aw_full;
		next_w_data = w_data;
		next_w_strb0 = w_strb0;
		next_w_full = w_full;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_arready = s_axi_arready;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		next_soft_start = 1'b0;
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_aw_addr = s_axi_awaddr;
			next_aw_full = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_w_data = s_axi_wdata;
			next_w_strb0 = s_axi_wstrb[0];
			next_w_full = 1'b1;
		end
		if (s_axi_bvalid && s_axi_bready)
			next_bvalid = 1'b0;
		if (aw_full && w_full && !s_axi_bvalid)
		begin
			next_aw_full = 1'b0;
			next_w_full = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = dual_conv_pkg::RESP_OKAY;
			if (aw_addr == dual_conv_pkg::CTRL_OFFSET)
				next_soft_start = w_strb0 && w_data[dual_conv_pkg::CTRL_START_BIT];
			else if (aw_addr != dual_conv_pkg::STATUS_OFFSET && aw_addr != dual_conv_pkg::OFFSET_EST_OFFSET)
				next_bresp = dual_conv_pkg::RESP_SLVERR;
		end
		next_awready = !next_aw_full;
		next_wready = !next_w_full;
		if (s_axi_rvalid && s_axi_rready)
		begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rdata = 32'h00000000;
			next_rresp = dual_conv_pkg::RESP_OKAY;
			case (s_axi_araddr)
				dual_conv_pkg::CTRL_OFFSET:
					next_rdata = 32'h00000000;
				dual_conv_pkg::STATUS_OFFSET:
					next_rdata = {28'h0000000, off_valid, correcting, pwr_state};
				dual_conv_pkg::OFFSET_EST_OFFSET:
					next_rdata = {5'h00, off_second, 5'h00, off_first};
				default:
					next_rresp = dual_conv_pkg::RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_addr <= '0;
			aw_full <= 1'b0;
			w_data <= '0;
			w_strb0 <= 1'b0;
			w_full <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= 2'h0;
			soft_start <= 1'b0;
		end
		else if (clk_en)
		begin
			aw_addr <= next_aw_addr;
			aw_full <= next_aw_full;
			w_data <= next_w_data;
			w_strb0 <= next_w_strb0;
			w_full <= next_w_full;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
			soft_start <= next_soft_start;
		end
	end

endmodule

// ---- dual_conv_pkg.sv ----
// Shared constants, types and register map of the dual converter output control block.
package dual_conv_pkg;

	// ****************************************************************
	// Data widths and code values
	// ****************************************************************
	localparam int RESULT_W = 10;
	localparam int ACC_W = 15;
	localparam int AVG_SHIFT = 5;
	localparam logic [10:0] MID_SCALE = 11'h200;
	localparam logic [9:0] CODE_MAX = 10'h3ff;

	// ****************************************************************
	// Correction sequence timing
	// ****************************************************************
	localparam logic [5:0] CORR_CYCLES = 6'h22;
	localparam logic [5:0] CORR_FIRST_ACC = 6'h01;
	localparam logic [5:0] CORR_LAST_ACC = 6'h20;

	// ****************************************************************
	// Wake-up timing; longest times round down to whole cycles
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int STANDBY_WAKE_NS = 800;
	localparam int POWER_DOWN_WAKE_NS = 1000000;
	localparam int STANDBY_WAKE_CYCLES = STANDBY_WAKE_NS / CLK_PERIOD_NS;
	localparam int POWER_DOWN_WAKE_CYCLES = POWER_DOWN_WAKE_NS / CLK_PERIOD_NS;
	localparam int WAKE_W = 17;

	// ****************************************************************
	// Register map and fields
	// ****************************************************************
	localparam logic [3:0] CTRL_OFFSET = 4'h0;
	localparam logic [3:0] STATUS_OFFSET = 4'h4;
	localparam logic [3:0] OFFSET_EST_OFFSET = 4'h8;
	localparam int CTRL_START_BIT = 0;
	localparam int STATUS_CORR_BIT = 2;
	localparam int STATUS_VALID_BIT = 3;
	localparam int OFFSET_SECOND_LSB = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0]
	{
		PWR_NORMAL = 2'b00,
		PWR_STANDBY = 2'b01,
		PWR_DOWN = 2'b10,
		PWR_WAKE = 2'b11
	} power_state_t;

	typedef struct packed
	{
		logic bus_select;
		logic offset_correct_start;
		logic output_format_select;
		logic standby_request;
		logic power_down_request;
	} control_pins_t;

	typedef struct packed
	{
		logic [9:0] first_channel;
		logic [9:0] second_channel;
	} sample_pair_t;

endpackage

// ---- dual_conv_capture.sv ----
// Model of the capture logic on the result side of the converter block.
`timescale 1ns/1ps

module dual_conv_capture (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Result side of the block.
	input wire logic bus_select,
	input wire logic [9:0] first_bus,
	input wire logic [9:0] second_bus,
	input wire logic indicator,
	// Last captured pair.
	output logic [9:0] cap_first,
	output logic [9:0] cap_second
);
	logic was_high;

	// Words are taken at the rising edge after the block has settled them.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			was_high <= 1'b0;
			cap_first <= 10'h000;
			cap_second <= 10'h000;
		end
		else
		begin
			was_high <= indicator;
			if (indicator)
			begin
				cap_first <= first_bus;
				cap_second <= bus_select ? second_bus : cap_second;
			end
			if (!indicator && was_high && !bus_select)
				cap_second <= first_bus;
		end
	end
endmodule

// ---- dual_conv_ctrl_props.sv ----
// Port checks of the dual converter output control block.
`timescale 1ns/1ps

module dual_conv_ctrl_props #(
	parameter int POWER_DOWN_WAKE = 20
)
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Pins and results.
	input wire dual_conv_pkg::control_pins_t control_pins,
	input wire logic [9:0] first_channel_result_bus,
	input wire logic [9:0] second_channel_result_bus,
	input wire logic channel_indicator
);
	localparam int STANDBY_REQUEST_BOUND = 104;
	wire logic sel = control_pins.bus_select;
	wire logic sby = control_pins.standby_request;
	wire logic pd = control_pins.power_down_request;
	wire logic quiet = !sby && !pd;
	logic [19:0] wait_cnt;
	logic [19:0] next_wait_cnt;
	logic pd_prev;

	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// Counts cycles from power-down release to the first pair; a counter keeps the long bound cheap.
	always_comb
	begin
		next_wait_cnt = wait_cnt;
		if (channel_indicator)
			next_wait_cnt = 20'h00000;
		else if ((pd_prev && !pd) || wait_cnt != 20'h00000)
			next_wait_cnt = wait_cnt + 20'h00001;
	end

	// Registers the counter and the previous power-down level.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wait_cnt <= 20'h00000;
			pd_prev <= 1'b0;
		end
		else
		begin
			wait_cnt <= next_wait_cnt;
			pd_prev <= pd;
		end
	end

	a_ind_one_cycle: assert property (channel_indicator |=> !channel_indicator)
		else $error("indicator high two cycles running");
	a_mux_second_low: assert property (!sel && !$past(sel) && !$past(sel, 2) && !$past(sel, 3)
		|-> second_channel_result_bus == 10'h000) else $error("second bus not low in mux mode");
	a_par_data_strobe: assert property (sel && $past(sel) && $past(sel, 2) && quiet && $past(quiet)
		&& first_channel_result_bus != $past(first_channel_result_bus) |-> channel_indicator)
		else $error("parallel data changed without indicator");
	a_par_word_hold: assert property (sel && $past(sel) && $past(sel, 2) && quiet && $past(quiet)
		&& !channel_indicator |-> $stable(first_channel_result_bus) && $stable(second_channel_result_bus))
		else $error("parallel word did not hold");
	a_standby_quiet: assert property (sby && $past(sby) && $past(sby, 2)
		|-> !channel_indicator && first_channel_result_bus == 10'h000) else $error("output during standby");
	a_pd_dominates: assert property (pd && sby && $past(pd && sby) && $past(pd && sby, 2)
		|-> !channel_indicator && second_channel_result_bus == 10'h000) else $error("output during power-down");
	a_standby_wake: assert property ($fell(sby) && !pd && !$past(pd)
		|-> ##[1:STANDBY_REQUEST_BOUND] channel_indicator) else $error("slow standby recovery");
	a_pd_wake: assert property (wait_cnt <= POWER_DOWN_WAKE + 4)
		else $error("slow power-down recovery");

	c_mux_pair: cover property (!sel && $past(channel_indicator) && !channel_indicator);
	c_standby_exit: cover property ($fell(sby));
	c_pd_exit: cover property ($fell(pd));
endmodule

bind dual_conv_ctrl dual_conv_ctrl_props #(.POWER_DOWN_WAKE(POWER_DOWN_WAKE)) dual_conv_ctrl_props_inst (
	.clk(clk),
	.rst_n(rst_n),
	.control_pins(control_pins),
	.first_channel_result_bus(first_channel_result_bus),
	.second_channel_result_bus(second_channel_result_bus),
	.channel_indicator(channel_indicator)
);

// ---- dual_adc_output_control_tb.sv ----
// Self-checking testbench of the dual converter output control block.
`timescale 1ns/1ps

module dual_adc_output_control_tb;
	localparam int PDW = 20;
	logic clk;
	logic rst_n;
	logic clk_en;
	dual_conv_pkg::control_pins_t pins;
	dual_conv_pkg::sample_pair_t raw;
	logic [9:0] first_bus;
	logic [9:0] second_bus;
	logic ind;
	logic [9:0] cap_first;
	logic [9:0] cap_second;
	logic [3:0] awaddr;
	logic [3:0] araddr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [31:0] d;
	logic [31:0] seed;
	logic [1:0] bresp;
	logic [1:0] rresp;
	logic [1:0] r;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	int n_errors;
	int checked;
	int off1;
	int off2;
	int n;

	dual_conv_ctrl #(.POWER_DOWN_WAKE(PDW)) dual_conv_ctrl_inst (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
		.control_pins(pins), .raw_codes(raw), .first_channel_result_bus(first_bus),
		.second_channel_result_bus(second_bus), .channel_indicator(ind), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	dual_conv_capture dual_conv_capture_inst (.clk(clk), .rst_n(rst_n), .bus_select(pins.bus_select),
		.first_bus(first_bus), .second_bus(second_bus), .indicator(ind), .cap_first(cap_first),
		.cap_second(cap_second));

	// ****
	// Model and shared tasks
	// ****
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Corrected, clamped and formatted word; two's complement flips the top bit.
	function automatic logic [9:0] expect_word(input int code, input int off, input logic fmt);
		int v;
		v = code - off;
		v = (v < 0) ? 0 : ((v > 1023) ? 1023 : v);
		return fmt ? (v[9:0] ^ 10'h200) : v[9:0];
	endfunction

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Holds codes steady, lets the capture settle, then compares both words.
	task automatic check_stream(input logic [9:0] a, input logic [9:0] b);
		raw <= {a, b};
		repeat (8) @(posedge clk);
		chk(cap_first, expect_word(a, off1, pins.output_format_select));
		chk(cap_second, expect_word(b, off2, pins.output_format_select));
		if (!pins.bus_select)
			chk(second_bus, 10'h000);
	endtask

	task automatic axi_read(input logic [3:0] a, output logic [31:0] dd, output logic [1:0] rr);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 64; i++)
		begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
			begin
				dd = rdata;
				rr = rresp;
				rready <= 1'b0;
				return;
			end
		end
		n_errors++;
		report_and_stop();
	endtask

	task automatic axi_write(input logic [3:0] a, input logic [31:0] dd, output logic [1:0] rr);
		@(posedge clk);
		awaddr <= a;
		wdata <= dd;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 64; i++)
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
			begin
				rr = bresp;
				bready <= 1'b0;
				return;
			end
		end
		n_errors++;
		report_and_stop();
	endtask

	// Counts edges until the next pair appears.
	task automatic wait_pair(output int cnt);
		for (cnt = 0; ind !== 1'b1; cnt++)
		begin
			if (cnt > PDW + 300)
			begin
				n_errors++;
				report_and_stop();
			end
			@(posedge clk);
		end
	endtask

	// Free-running 125 MHz clock.
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ****
	// Main sequence
	// ****
	initial
	begin
		{rst_n, pins, raw, awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
		clk_en = 1'b1;
		{n_errors, checked, off1, off2} = '0;
		seed = 32'hf7346d0b;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		for (int m = 0; m < 4; m++)
		begin
			pins <= {m[0], 1'b0, m[1], 2'b00};
			seed = lfsr_next(seed);
			check_stream(seed[9:0], seed[19:10]);
		end
		pins <= 5'h10;
		raw <= {10'h208, 10'h1f4};
		repeat (4) @(posedge clk);
		pins <= 5'h18;
		axi_read(4'h4, d, r);
		chk(d & 32'h4, 32'h4);
		repeat (40) @(posedge clk);
		axi_read(4'h4, d, r);
		chk(d & 32'hc, 32'h8);
		axi_read(4'h8, d, r);
		chk(d, 32'h07f40008);
		off1 = 8;
		off2 = -12;
		seed = lfsr_next(seed);
		check_stream(seed[9:0], 10'h3fa);
		pins <= 5'h12;
		repeat (6) @(posedge clk);
		chk({ind, first_bus}, 11'h000);
		pins <= 5'h10;
		wait_pair(n);
		chk(n <= 102, 1'b1);
		check_stream(10'h003, 10'h005);
		pins <= 5'h13;
		repeat (4) @(posedge clk);
		axi_read(4'h4, d, r);
		chk(d & 32'h3, 32'h2);
		pins <= 5'h10;
		wait_pair(n);
		chk(n <= PDW + 3, 1'b1);
		raw <= {10'h200, 10'h200};
		axi_write(4'h0, 32'h1, r);
		chk(r, 2'h0);
		repeat (40) @(posedge clk);
		axi_read(4'h8, d, r);
		chk(d, 32'h0);
		axi_write(4'hc, 32'h1, r);
		chk(r, 2'h2);
		axi_read(4'hc, d, r);
		chk({d[29:0], r}, 32'h2);
		report_and_stop();
	end
endmodule
